// ---- tsr_regs.sv ----
// serial register interface, conversion timing and limit compare
//
// Behaviour
// - every register is eight bits wide
// - local result is an eight bit value
// - each channel result is compared with its high and low limits
// - first byte of each write loads the register pointer
// - second write byte goes to the pointed register; reads return it
// - pointer is 0x00 at power-on
// - read right after power-on returns the local result
// - config one read at 0x03, written at 0x09
// - config two read and written at 0x24
// - writing bit 7 of config two sets lock; lock resets to 0
// - lock and locked registers hold until power is cycled
// - config two bits 6 to 0 have no function
// - conversion rate read at 0x04, written at 0x0a
// - low four rate bits set period, 16 s at 0x00 down to 15.625 ms at 0x0a
// - rate 0x0b runs conversions back to back
// - status registers at 0x02 and 0x23 are read only
// - default range reports plain binary degrees
// - extended range reports degrees plus 64
// - plain binary reports zero below zero degrees
// - plain binary reports 127 above 127 degrees
// - write to 0x0f in standby runs one conversion; data dropped
// - config one bit 3 picks remote one or two at shared addresses
`timescale 1ns/10ps
`default_nettype none
module tsr_regs #(
    parameter longint PERIOD_MAX_CYC = tsr_pkg::PERIOD_MAX_CYC,
    parameter longint CONV_CYC       = tsr_pkg::CONV_CYC
) (
    // clock and power-on reset
    input  wire logic               sys_clk,
    input  wire logic               resetn,
    // two-wire bus pins
    input  wire logic               scl_in,
    input  wire logic               sda_in,
    output logic                    sda_out,
    output logic                    sda_oe_n,
    // analog front end
    input  wire tsr_pkg::tsr_temps_s temps,
    output logic                    conv_busy
);
    import tsr_pkg::*;

    logic [2:0]  scl_sync, sda_sync;
    logic        scl_f, sda_f, scl_d, sda_d;
    tsr_bus_e    state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic        rw, second_byte, lock;
    logic [7:0]  ptr, cfg1, rate, rd_data;
    logic [7:0]  val [3];
    logic [7:0]  hi_lim [3];
    logic [7:0]  lo_lim [3];
    logic [7:0]  enc [3];
    logic [2:0]  hi_flag, lo_flag;
    logic        ptr_load, wr_pulse, scl_rise, scl_fall;
    logic        start_c, stop_c;
    logic [1:0]  rsel;
    logic [31:0] per_cnt, period, conv_cnt;
    logic        conv_end, one_shot, start_conv, cont, standby;

    // three-stage pin sync; filtered level moves once stages two and three agree
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_f    <= 1'b1;
            sda_f    <= 1'b1;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
            if (scl_sync[1] == scl_sync[2]) begin
                scl_f <= scl_sync[2];
            end
            if (sda_sync[1] == sda_sync[2]) begin
                sda_f <= sda_sync[2];
            end
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    assign scl_rise = scl_f && !scl_d;
    assign scl_fall = !scl_f && scl_d;
    assign start_c  = scl_f && scl_d && sda_d && !sda_f;
    assign stop_c   = scl_f && scl_d && !sda_d && sda_f;
    assign ptr_load = scl_fall && state == TSR_RX && bit_cnt == 4'h8
                      && !second_byte;
    assign wr_pulse = scl_fall && state == TSR_RX && bit_cnt == 4'h8
                      && second_byte;

    // byte level slave; write is pointer then data bytes, each stored at the same pointer
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state       <= TSR_IDLE;
            bit_cnt     <= 4'h0;
            shreg       <= 8'h00;
            rw          <= 1'b0;
            second_byte <= 1'b0;
        end else if (start_c) begin
            state       <= TSR_ADDR;
            bit_cnt     <= 4'h0;
            second_byte <= 1'b0;
        end else if (stop_c) begin
            state <= TSR_IDLE;
        end else begin
            case (state)
                TSR_ADDR, TSR_RX: begin
                    if (scl_rise) begin
                        shreg   <= {shreg[6:0], sda_f};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        if (state == TSR_RX) begin
                            second_byte <= 1'b1;
                            state       <= TSR_ACK_R;
                        end else if (shreg[7:1] == BUS_ADDR) begin
                            rw    <= shreg[0];
                            state <= TSR_ACK_A;
                        end else begin
                            state <= TSR_WAIT;
                        end
                    end
                end
                TSR_ACK_A: begin
                    if (scl_fall) begin
                        if (rw) begin
                            shreg <= rd_data;
                            state <= TSR_TX;
                        end else begin
                            state <= TSR_RX;
                        end
                    end
                end
                TSR_ACK_R: begin
                    if (scl_fall) begin
                        state <= TSR_RX;
                    end
                end
                TSR_TX: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt == 4'h8) begin
                            bit_cnt <= 4'h0;
                            state   <= TSR_ACK_T;
                        end else begin
                            shreg <= {shreg[6:0], 1'b0};
                        end
                    end
                end
                TSR_ACK_T: begin
                    if (scl_rise && sda_f) begin
                        state <= TSR_WAIT;
                    end else if (scl_fall) begin
                        shreg <= rd_data;
                        state <= TSR_TX;
                    end
                end
                default: state <= state;
            endcase
        end
    end

    // open drain: enable low pulls the line low
    assign sda_out  = 1'b0;
    assign sda_oe_n = !(state == TSR_ACK_A || state == TSR_ACK_R
                        || (state == TSR_TX && !shreg[7]));

    // pointer
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ptr <= PTR_RST;
        end else if (ptr_load) begin
            ptr <= shreg;
        end
    end

    assign rsel    = cfg1[CFG1_RSEL_BIT] ? 2'd2 : 2'd1;
    assign standby = cfg1[CFG1_STANDBY_BIT];

    // configuration, rate and limits; lock blocks them all
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cfg1 <= CFG1_RST;
            rate <= RATE_RST;
            lock <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                hi_lim[i] <= HI_LIM_RST;
                lo_lim[i] <= LO_LIM_RST;
            end
        end else if (wr_pulse) begin
            if (ptr == RW_CONFIG_TWO && shreg[CFG2_LOCK_BIT]) begin
                lock <= 1'b1;
            end
            if (!lock) begin
                case (ptr)
                    WR_CONFIG_ONE: cfg1 <= shreg;
                    WR_CONV_RATE:  rate <= shreg;
                    WR_LOCAL_HI:   hi_lim[0] <= shreg;
                    WR_LOCAL_LO:   lo_lim[0] <= shreg;
                    WR_REMOTE_HI:  hi_lim[rsel] <= shreg;
                    WR_REMOTE_LO:  lo_lim[rsel] <= shreg;
                    default:       cfg1 <= cfg1;
                endcase
            end
        end
    end

    // read decode; values outside the map read as zero
    always_comb begin
        case (ptr)
            RD_LOCAL_VAL:  rd_data = val[0];
            RD_REMOTE_VAL: rd_data = val[rsel];
            RD_STATUS_ONE: rd_data = {1'b0, hi_flag[0], lo_flag[0],
                                      hi_flag[1], lo_flag[1], 3'h0};
            RD_CONFIG_ONE: rd_data = cfg1;
            RD_CONV_RATE:  rd_data = rate;
            RD_LOCAL_HI:   rd_data = hi_lim[0];
            RD_LOCAL_LO:   rd_data = lo_lim[0];
            RD_REMOTE_HI:  rd_data = hi_lim[rsel];
            RD_REMOTE_LO:  rd_data = lo_lim[rsel];
            RD_STATUS_TWO: rd_data = {3'h0, hi_flag[2], lo_flag[2], 3'h0};
            RW_CONFIG_TWO: rd_data = {lock, 7'h00};
            default:       rd_data = 8'h00;
        endcase
    end

    // conversion scheduling; 16 s halves per code, so code 0x0a is ~15.6 ms
    assign period   = 32'(PERIOD_MAX_CYC >> rate[3:0]);
    assign cont     = rate[3:0] >= RATE_CONT;
    assign conv_end = conv_busy && conv_cnt == 32'(CONV_CYC - 1);
    assign start_conv = !conv_busy && (standby ? one_shot
                        : (cont || per_cnt >= period - 32'h1));

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            per_cnt <= 32'h0;
        end else if (standby || start_conv) begin
            per_cnt <= 32'h0;
        end else if (per_cnt < period - 32'h1) begin
            per_cnt <= per_cnt + 32'h1;
        end
    end

    // one-shot request: a new write wins over the clear by start
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            one_shot <= 1'b0;
        end else if (wr_pulse && ptr == WR_ONE_SHOT && standby) begin
            one_shot <= 1'b1;
        end else if (start_conv || !standby) begin
            one_shot <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            conv_busy <= 1'b0;
            conv_cnt  <= 32'h0;
        end else if (start_conv) begin
            conv_busy <= 1'b1;
            conv_cnt  <= 32'h0;
        end else if (conv_end) begin
            conv_busy <= 1'b0;
        end else if (conv_busy) begin
            conv_cnt <= conv_cnt + 32'h1;
        end
    end

    // per channel encode, store and compare at the end of each conversion
    for (genvar g = 0; g < 3; g++) begin : g_chan
        logic signed [9:0] t;
        logic signed [10:0] o;
        assign t = temps[g*10 +: 10];
        // one bit wider so hot inputs cannot wrap past the clamp
        assign o = 11'(t) + 11'(ENC_OFFSET);
        always_comb begin
            if (cfg1[CFG1_RANGE_BIT]) begin
                enc[g] = o < 0 ? 8'h00 : (o > OFS_MAX ? 8'hff : o[7:0]);
            end else if (t < 0) begin
                enc[g] = 8'h00;
            end else begin
                enc[g] = t > BIN_MAX ? BIN_MAX[7:0] : t[7:0];
            end
        end
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                val[g]     <= VAL_RST;
                hi_flag[g] <= 1'b0;
                lo_flag[g] <= 1'b0;
            end else if (conv_end) begin
                val[g]     <= enc[g];
                hi_flag[g] <= enc[g] > hi_lim[g];
                lo_flag[g] <= enc[g] < lo_lim[g];
            end
        end
        flag_cmp_a: assert property (@(posedge sys_clk)
            disable iff (!resetn)
            conv_end |=> hi_flag[g] == ($past(enc[g]) > $past(hi_lim[g])))
            else $error("high flag does not match compare");
        bin_clamp_a: assert property (@(posedge sys_clk)
            disable iff (!resetn) !cfg1[CFG1_RANGE_BIT]
            |-> enc[g] <= 8'h7f && (t >= 0 || enc[g] == 0))
            else $error("binary result out of clamp");
        ofs_enc_a: assert property (@(posedge sys_clk)
            disable iff (!resetn) cfg1[CFG1_RANGE_BIT] && t >= -64 && t <= 191
            |-> enc[g] == 8'(t + 10'sd64))
            else $error("offset binary result wrong");
    end

    ptr_load_a: assert property (@(posedge sys_clk)
        disable iff (!resetn) !$stable(ptr) |-> $past(ptr_load))
        else $error("pointer changed without first write byte");
    lock_hold_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        lock |=> lock && $stable(cfg1) && $stable(rate) && $stable(hi_lim[0]))
        else $error("locked state changed");
    store_write_a: assert property (@(posedge sys_clk)
        disable iff (!resetn) wr_pulse && ptr == WR_LOCAL_HI && !lock
        |=> hi_lim[0] == $past(shreg))
        else $error("write data not stored");
    cont_conv_a: assert property (@(posedge sys_clk)
        disable iff (!resetn) conv_end ##1 (cont && !standby) |=> conv_busy)
        else $error("continuous conversion idled");
    one_shot_a: assert property (@(posedge sys_clk)
        disable iff (!resetn) wr_pulse && ptr == WR_ONE_SHOT && standby
        && !conv_busy |=> ##[0:1] conv_busy)
        else $error("one shot did not start conversion");
endmodule
`default_nettype wire

// ---- tsr_pkg.sv ----
// shared constants and types of the temperature monitor register logic
package tsr_pkg;
    // clock and timing
    localparam longint CLK_HZ         = 25_000_000;
    localparam longint PERIOD_MAX_MS  = 16_000;
    localparam longint PERIOD_MAX_CYC = PERIOD_MAX_MS * CLK_HZ / 1000;
    localparam longint CONV_TIME_US   = 1_000;
    localparam longint CONV_CYC       = CONV_TIME_US * CLK_HZ / 1_000_000;
    // register read addresses
    localparam logic [7:0] RD_LOCAL_VAL  = 8'h00;
    localparam logic [7:0] RD_REMOTE_VAL = 8'h01;
    localparam logic [7:0] RD_STATUS_ONE = 8'h02;
    localparam logic [7:0] RD_CONFIG_ONE = 8'h03;
    localparam logic [7:0] RD_CONV_RATE  = 8'h04;
    localparam logic [7:0] RD_LOCAL_HI   = 8'h05;
    localparam logic [7:0] RD_LOCAL_LO   = 8'h06;
    localparam logic [7:0] RD_REMOTE_HI  = 8'h07;
    localparam logic [7:0] RD_REMOTE_LO  = 8'h08;
    localparam logic [7:0] RD_STATUS_TWO = 8'h23;
    localparam logic [7:0] RW_CONFIG_TWO = 8'h24;
    // register write addresses
    localparam logic [7:0] WR_CONFIG_ONE = 8'h09;
    localparam logic [7:0] WR_CONV_RATE  = 8'h0a;
    localparam logic [7:0] WR_LOCAL_HI   = 8'h0b;
    localparam logic [7:0] WR_LOCAL_LO   = 8'h0c;
    localparam logic [7:0] WR_REMOTE_HI  = 8'h0d;
    localparam logic [7:0] WR_REMOTE_LO  = 8'h0e;
    localparam logic [7:0] WR_ONE_SHOT   = 8'h0f;
    // field positions
    localparam int CFG1_STANDBY_BIT = 6;
    localparam int CFG1_RSEL_BIT    = 3;
    localparam int CFG1_RANGE_BIT   = 2;
    localparam int CFG2_LOCK_BIT    = 7;
    localparam int ST_HI_BIT        = 4;
    localparam int ST_LO_BIT        = 3;
    localparam int ST_LOC_HI_BIT    = 6;
    localparam int ST_LOC_LO_BIT    = 5;
    // reset values and the continuous rate code
    localparam logic [7:0] PTR_RST      = 8'h00;
    localparam logic [7:0] CFG1_RST     = 8'h00;
    localparam logic [7:0] RATE_RST     = 8'h07;
    localparam logic [7:0] HI_LIM_RST   = 8'h55;
    localparam logic [7:0] LO_LIM_RST   = 8'h00;
    localparam logic [7:0] VAL_RST      = 8'h00;
    localparam logic [3:0] RATE_CONT    = 4'hb;
    // encoding
    localparam logic signed [9:0] BIN_MAX    = 10'sd127;
    localparam logic signed [9:0] ENC_OFFSET = 10'sd64;
    localparam logic signed [9:0] OFS_MAX    = 10'sd255;
    // bus address of this device, value arbitrary
    localparam logic [6:0] BUS_ADDR = 7'h2a;
    // measured temperatures in whole degrees, two's complement
    typedef struct packed {
        logic signed [9:0] remote_two;
        logic signed [9:0] remote_one;
        logic signed [9:0] local_t;
    } tsr_temps_s;
    typedef enum {TSR_IDLE, TSR_ADDR, TSR_ACK_A, TSR_RX, TSR_ACK_R,
                  TSR_TX, TSR_ACK_T, TSR_WAIT} tsr_bus_e;
endpackage

// ---- tsr_host.sv ----
// two-wire bus host model that reads and writes device registers
`timescale 1ns/10ps
`default_nettype none
module tsr_host #(
    parameter int HALF = 8
) (
    // clock
    input  wire logic       sys_clk,
    // bus wires, scl is only driven by this host
    input  wire logic       sda,
    output var  logic       scl,
    output var  logic       sda_pull,
    // acknowledges the device failed to give
    output var  logic [7:0] nacks
);
    import tsr_pkg::*;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        nacks = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // data moves a few cycles after scl falls, never while scl is high
    task automatic put_bit(input logic b);
        sda_pull <= ~b;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        scl <= 1'b0;
        tick(4);
    endtask
    task automatic get_bit(output logic b);
        sda_pull <= 1'b0;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF - 1);
        @(negedge sys_clk);
        b = sda;
        @(posedge sys_clk);
        scl <= 1'b0;
        tick(4);
    endtask
    task automatic put_byte(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(a);
        if (a !== 1'b0) begin
            nacks <= nacks + 8'h01;
        end
    endtask
    task automatic start_cond();
        @(posedge sys_clk);
        sda_pull <= 1'b1;
        tick(HALF);
        scl <= 1'b0;
        tick(4);
    endtask
    task automatic stop_cond();
        sda_pull <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_pull <= 1'b0;
        tick(HALF);
    endtask
    // pointer byte, then at most one data byte
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d,
                      input int n);
        start_cond();
        put_byte({BUS_ADDR, 1'b0});
        put_byte(ptr);
        if (n == 2) begin
            put_byte(d);
        end
        stop_cond();
    endtask
    // exactly one byte, ended by a nack
    task automatic rd(output logic [7:0] d);
        logic b;
        start_cond();
        put_byte({BUS_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) begin
            get_bit(b);
            d[i] = b;
        end
        put_bit(1'b1);
        stop_cond();
    endtask
endmodule
`default_nettype wire

// ---- tb_tsr_regs.sv ----
// self-checking bench for the temperature monitor register logic
`timescale 1ns/10ps
`default_nettype none
module tb_tsr_regs;
    import tsr_pkg::*;
    localparam int PER_MAX = 4096;
    localparam int CONV    = 8;
    typedef struct packed {
        logic [7:0]        wa;
        logic [7:0]        wd;
        logic [7:0]        ra;
        logic [7:0]        ex;
        logic signed [9:0] t;
    } tsr_row_s;
    logic            sys_clk   = 1'b0;
    logic            resetn    = 1'b0;
    tsr_temps_s      temps     = '{10'sd40, 10'sd30, 10'sd25};
    wire logic       scl;
    wire logic       sda;
    wire logic       sda_pull;
    wire logic       sda_out;
    wire logic       sda_oe_n;
    wire logic       conv_busy;
    wire logic [7:0] nacks;
    int              errors    = 0;
    int              tests_run = 0;
    int              c;
    int              g;
    int              lo;
    int              per;
    logic [7:0]      d;
    logic [7:0]      codes [3] = '{8'h00, 8'h04, 8'h0b};
    logic [7:0]      rst_a [5] = '{RW_CONFIG_TWO, RD_LOCAL_HI, RD_CONV_RATE,
                                   RD_CONFIG_ONE, RD_REMOTE_LO};
    logic [7:0]      rst_v [5] = '{8'h00, HI_LIM_RST, RATE_RST, CFG1_RST,
                                   LO_LIM_RST};
    tsr_row_s        rows [16] = '{
        '{WR_CONV_RATE,  8'h0b, RD_CONV_RATE,  8'h0b, 10'sd25},
        '{WR_LOCAL_HI,   8'h14, RD_LOCAL_HI,   8'h14, 10'sd25},
        '{WR_LOCAL_LO,   8'h05, RD_STATUS_ONE, 8'h40, 10'sd25},
        '{WR_REMOTE_LO,  8'h32, RD_REMOTE_LO,  8'h32, 10'sd25},
        '{RD_STATUS_ONE, 8'h00, RD_STATUS_ONE, 8'h48, 10'sd25},
        '{RD_STATUS_TWO, 8'hff, RD_STATUS_TWO, 8'h00, 10'sd25},
        '{WR_CONFIG_ONE, 8'h00, RD_LOCAL_VAL,  8'h00, -10'sd10},
        '{WR_CONFIG_ONE, 8'h00, RD_LOCAL_VAL,  8'h7f, 10'sd150},
        '{WR_CONFIG_ONE, 8'h08, RD_REMOTE_VAL, 8'h28, 10'sd150},
        '{WR_CONFIG_ONE, 8'h08, RD_CONFIG_ONE, 8'h08, 10'sd25},
        '{WR_CONFIG_ONE, 8'h04, RD_LOCAL_VAL,  8'h59, 10'sd25},
        '{WR_CONFIG_ONE, 8'h04, RD_LOCAL_VAL,  8'h09, -10'sd55},
        '{WR_CONFIG_ONE, 8'h04, RD_LOCAL_VAL,  8'hff, 10'sd200},
        '{WR_CONFIG_ONE, 8'h04, RD_REMOTE_VAL, 8'h5e, 10'sd25},
        '{RW_CONFIG_TWO, 8'h7f, RW_CONFIG_TWO, 8'h00, 10'sd25},
        '{WR_CONFIG_ONE, 8'h00, RD_LOCAL_VAL,  8'h19, 10'sd25}};
    // open-drain wire with pull-up
    assign sda = ~sda_pull & (sda_oe_n | sda_out);
    always #20 sys_clk = ~sys_clk;
    tsr_regs #(.PERIOD_MAX_CYC(PER_MAX), .CONV_CYC(CONV)) tsr_regs_i (
        .sys_clk(sys_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .temps(temps),
        .conv_busy(conv_busy));
    tsr_host tsr_host_i (.sys_clk(sys_clk), .sda(sda), .scl(scl),
        .sda_pull(sda_pull), .nacks(nacks));
    task automatic end_of_test();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rd_at(input logic [7:0] a, output logic [7:0] v);
        tsr_host_i.wr(a, 8'h00, 1);
        tsr_host_i.rd(v);
    endtask
    // cycles until conv_busy next turns to lvl, capped so a stall ends
    task automatic edge_wait(input logic lvl, output int n);
        logic p;
        n = 0;
        p = lvl;
        while (n < 6000 && !(p === ~lvl && conv_busy === lvl)) begin
            p = conv_busy;
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge sys_clk);
        tsr_host_i.rd(d);
        chk("power-on read", d, 8'h19);
        foreach (rows[i]) begin
            temps.local_t <= rows[i].t;
            tsr_host_i.wr(rows[i].wa, rows[i].wd, 2);
            // two falls make sure a whole conversion saw the new setting
            edge_wait(1'b0, c);
            edge_wait(1'b0, c);
            rd_at(rows[i].ra, d);
            chk($sformatf("row %0d", i), d, rows[i].ex);
        end
        foreach (codes[k]) begin
            tsr_host_i.wr(WR_CONV_RATE, codes[k], 2);
            edge_wait(1'b1, c);
            edge_wait(1'b1, g);
            per = (codes[k] >= 8'h0b) ? 0 : (PER_MAX >> codes[k]);
            lo = (per > CONV) ? per : CONV;
            chk("rate gap", 8'(g >= lo && g <= per + CONV + 3), 8'h01);
        end
        tsr_host_i.wr(WR_CONFIG_ONE, 8'h40, 2);
        repeat (40) @(posedge sys_clk);
        temps.local_t <= 10'sd60;
        edge_wait(1'b1, c);
        chk("standby idle", 8'(c >= 6000), 8'h01);
        rd_at(RD_LOCAL_VAL, d);
        chk("standby hold", d, 8'h19);
        tsr_host_i.wr(WR_ONE_SHOT, 8'h5a, 2);
        repeat (40) @(posedge sys_clk);
        rd_at(RD_LOCAL_VAL, d);
        chk("one-shot", d, 8'h3c);
        tsr_host_i.wr(RW_CONFIG_TWO, 8'h80, 2);
        tsr_host_i.wr(WR_LOCAL_HI, 8'h70, 2);
        tsr_host_i.wr(RW_CONFIG_TWO, 8'h00, 2);
        rd_at(RD_LOCAL_HI, d);
        chk("locked limit", d, 8'h14);
        rd_at(RW_CONFIG_TWO, d);
        chk("lock stays", d, 8'h80);
        // power cycle: only this may clear the lock
        resetn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge sys_clk);
        tsr_host_i.rd(d);
        chk("reset pointer", d, 8'h3c);
        foreach (rst_a[k]) begin
            rd_at(rst_a[k], d);
            chk("reset value", d, rst_v[k]);
        end
        chk("acks", nacks, 8'h00);
        end_of_test();
    end
    initial begin
        // a clean run needs about 50k cycles, the largest part the sixteen register rows
        repeat (80000) @(posedge sys_clk);
        errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
